// ### scpc_pkg.sv
// Shared constants and types for the smart card pin control and status block
package scpc_pkg;

    // ********
    // Bus geometry
    // ********
    localparam int SCPC_ADDR_W = 8;  // Byte address width
    localparam int SCPC_DATA_W = 32; // Data width

    // ********
    // Register offsets (byte addresses)
    // ********
    localparam logic [7:0] SCPC_OFF_CTRL = 8'h00;     // Control
    localparam logic [7:0] SCPC_OFF_PIN = 8'h04;      // Pin control and status
    localparam logic [7:0] SCPC_OFF_INT_STAT = 8'h08; // Sticky event status, read only
    localparam logic [7:0] SCPC_OFF_INT_CLR = 8'h0c;  // Event clear, write only
    localparam logic [7:0] SCPC_OFF_INT_EN = 8'h10;   // Event enable

    // ********
    // Control register fields
    // ********
    localparam int SCPC_CTRL_ENABLE = 0;     // interface_enable
    localparam int SCPC_CTRL_AUTO_DEACT = 1; // auto_deactivate_on_removal
    localparam int SCPC_CTRL_PWR_INV = 2;    // power_invert_bit
    localparam int SCPC_CTRL_GO_ACT = 4;     // Start activation, self clearing
    localparam int SCPC_CTRL_GO_WARM = 5;    // Start warm reset, self clearing
    localparam int SCPC_CTRL_GO_DEACT = 6;   // Start deactivation, self clearing

    // ********
    // Pin control and status fields
    // ********
    localparam int SCPC_PIN_PWR = 0;     // power_enable_bit
    localparam int SCPC_PIN_RST = 1;     // card_reset_line level
    localparam int SCPC_PIN_REM = 2;     // card_removed_flag
    localparam int SCPC_PIN_INS = 3;     // card_inserted_flag
    localparam int SCPC_PIN_DETECT = 4;  // card_detect_level
    localparam int SCPC_PIN_RSVD = 5;    // Reserved, reads zero

    // ********
    // Event status / clear / enable fields
    // ********
    localparam int SCPC_EV_INS = 0;      // Card inserted
    localparam int SCPC_EV_REM = 1;      // Card removed
    localparam int SCPC_EV_SEQ_END = 2;  // Sequence finished (initial end)
    localparam int SCPC_EV_W = 3;        // Number of events

    // ********
    // Reset values
    // ********
    localparam logic SCPC_RST_ENABLE = 1'b0;
    localparam logic SCPC_RST_AUTO_DEACT = 1'b0;
    localparam logic SCPC_RST_PWR_INV = 1'b0;
    localparam logic SCPC_RST_PWR_EN = 1'b0;
    localparam logic SCPC_RST_RESET_LINE = 1'b0;
    localparam logic [SCPC_EV_W-1:0] SCPC_RST_INT_EN = 3'h0;

    // ********
    // Timing: one sequencer step
    // ********
    localparam int SCPC_CLK_PERIOD_NS = 10;   // core_clk at 100 MHz
    localparam int SCPC_STEP_TIME_NS = 1000;  // Least time per sequence step
    localparam int SCPC_STEP_CYCLES =
        (SCPC_STEP_TIME_NS + SCPC_CLK_PERIOD_NS - 1) / SCPC_CLK_PERIOD_NS;
    localparam int SCPC_STEP_CNT_W = $clog2(SCPC_STEP_CYCLES + 1);

    // ********
    // Types
    // ********
    typedef struct packed {
        logic [SCPC_ADDR_W-1:0] addr;  // Byte address
        logic [SCPC_DATA_W-1:0] wdata; // Write data
        logic wr;                      // Write strobe
        logic rd;                      // Read strobe
    } scpc_bus_req_t;

    typedef enum logic [2:0] {
        SCPC_SEQ_IDLE,
        SCPC_SEQ_ACT_PWR,
        SCPC_SEQ_ACT_REL,
        SCPC_SEQ_WARM_LOW,
        SCPC_SEQ_WARM_REL,
        SCPC_SEQ_DEACT_RST,
        SCPC_SEQ_DEACT_PWR
    } scpc_seq_state_t;

endpackage

// ### scpc_sync.sv
// Three-stage synchroniser with agreement filter for the card-detect pin
`timescale 1ns/1ps
module scpc_sync
    import scpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic pin_async,
    output logic level
);

    // ********************************************************
    // Synchroniser stages
    // ********************************************************
    logic s1_reg; // Metastability catcher, read only by s2
    logic s2_reg; // Second stage
    logic s3_reg; // Third stage
    logic level_reg; // Accepted level
    logic level_next; // Next accepted level

    // Accept a change only once stages two and three agree
    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
    end

    // Register stages and accepted level
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg <= pin_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;

endmodule

// ### scpc_seq.sv
// Activation, warm reset and deactivation sequencer for reset and power pins
`timescale 1ns/1ps
module scpc_seq
    import scpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic go_act,
    input wire logic go_warm,
    input wire logic go_deact,
    output logic busy,
    output logic seq_rst,
    output logic seq_pwr,
    output logic done
);

    // ********************************************************
    // State and step timer
    // ********************************************************
    scpc_seq_state_t state_reg; // Current step
    scpc_seq_state_t state_next; // Next step
    logic [SCPC_STEP_CNT_W-1:0] cnt_reg; // Step divider
    logic [SCPC_STEP_CNT_W-1:0] cnt_next; // Next divider value
    logic done_reg; // Finish pulse
    logic done_next; // Next finish pulse
    logic tick; // One-cycle step enable

    // Step enable from the divider
    assign tick = (cnt_reg == SCPC_STEP_CNT_W'(SCPC_STEP_CYCLES - 1));

    // Next state; deactivation aborts a running activation or warm reset
    always_comb begin
        state_next = state_reg;
        cnt_next = tick ? '0 : cnt_reg + 1'b1;
        done_next = 1'b0;
        case (state_reg)
            SCPC_SEQ_IDLE: begin
                cnt_next = '0;
                if (go_deact) begin
                    state_next = SCPC_SEQ_DEACT_RST;
                end else if (go_warm) begin
                    state_next = SCPC_SEQ_WARM_LOW;
                end else if (go_act) begin
                    state_next = SCPC_SEQ_ACT_PWR;
                end
            end
            SCPC_SEQ_ACT_PWR: if (tick) state_next = SCPC_SEQ_ACT_REL;
            SCPC_SEQ_WARM_LOW: if (tick) state_next = SCPC_SEQ_WARM_REL;
            SCPC_SEQ_DEACT_RST: if (tick) state_next = SCPC_SEQ_DEACT_PWR;
            SCPC_SEQ_ACT_REL, SCPC_SEQ_WARM_REL, SCPC_SEQ_DEACT_PWR: begin
                if (tick) begin
                    state_next = SCPC_SEQ_IDLE;
                    done_next = 1'b1;
                end
            end
            default: state_next = SCPC_SEQ_IDLE;
        endcase
        // Abort into deactivation from a non-deactivation step
        if (go_deact && state_reg != SCPC_SEQ_IDLE && state_reg != SCPC_SEQ_DEACT_RST
            && state_reg != SCPC_SEQ_DEACT_PWR) begin
            state_next = SCPC_SEQ_DEACT_RST;
            cnt_next = '0;
            done_next = 1'b0;
        end
    end

    // Register sequencer state
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_reg <= SCPC_SEQ_IDLE;
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
        end
    end

    // Pin levels demanded by each step
    always_comb begin
        seq_rst = 1'b0;
        seq_pwr = 1'b0;
        case (state_reg)
            SCPC_SEQ_ACT_PWR, SCPC_SEQ_WARM_LOW, SCPC_SEQ_DEACT_RST: seq_pwr = 1'b1;
            SCPC_SEQ_ACT_REL, SCPC_SEQ_WARM_REL: begin
                seq_rst = 1'b1;
                seq_pwr = 1'b1;
            end
            default: seq_pwr = 1'b0;
        endcase
    end

    assign busy = (state_reg != SCPC_SEQ_IDLE);
    assign done = done_reg;

endmodule

// ### scpc_top.sv
// Smart card pin control and status: registers, card detect, reset and power pins
//
// Overview of operation
// RULE_01: Status bit mirrors synchronised card-detect pin level
// RULE_02: Insertion sets inserted flag; writing zero ignored
// RULE_03: Removal sets removed flag; writing zero ignored
// RULE_04: Software cannot set flags; writing one clears
// RULE_05: Detection idle until interface enable is set
// RULE_06: Written reset bit drives the reset pin
// RULE_07: Reading reset bit returns reset pin level
// RULE_08: Sequences own reset/power bits; software writes ignored
// RULE_09: Power pin equals enable XOR invert
// RULE_10: Reading power bit returns power pin level
// RULE_11: Bit five reserved, reads zero
// RULE_12: Auto deactivation on removal, then end interrupt
// RULE_13: Card-detect pin synchronised before any use
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module scpc_top
    import scpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire scpc_bus_req_t bus_req,
    output logic [SCPC_DATA_W-1:0] rdata,
    input wire logic card_detect_pin,
    output logic card_reset_line,
    output logic card_power_pin,
    output logic irq
);

    // ********
    // Bus decode
    // ********
    logic wr_ctrl; // Write to control
    logic wr_pin; // Write to pin control and status
    logic wr_clr; // Write to event clear
    logic wr_en; // Write to event enable
    logic [SCPC_DATA_W-1:0] wd; // Write data alias

    assign wd = bus_req.wdata;
    assign wr_ctrl = bus_req.wr && (bus_req.addr == SCPC_OFF_CTRL);
    assign wr_pin = bus_req.wr && (bus_req.addr == SCPC_OFF_PIN);
    assign wr_clr = bus_req.wr && (bus_req.addr == SCPC_OFF_INT_CLR);
    assign wr_en = bus_req.wr && (bus_req.addr == SCPC_OFF_INT_EN);

    // ********
    // Card detect synchroniser
    // ********
    logic detect_level; // Filtered card-detect level

    // Three-flop filter keeps a level seen for only one cycle from making false edges
    scpc_sync u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .pin_async(card_detect_pin),
        .level(detect_level)
    ); // [RULE_13]

    // ********
    // Control register
    // ********
    logic enable_reg; // interface_enable
    logic enable_next;
    logic auto_deact_reg; // auto_deactivate_on_removal
    logic auto_deact_next;
    logic pwr_inv_reg; // power_invert_bit
    logic pwr_inv_next;
    logic go_act; // Start pulses, not stored
    logic go_warm;
    logic go_deact_sw;

    // Start commands are plain pulses from the write itself
    assign go_act = wr_ctrl && wd[SCPC_CTRL_GO_ACT];
    assign go_warm = wr_ctrl && wd[SCPC_CTRL_GO_WARM];
    assign go_deact_sw = wr_ctrl && wd[SCPC_CTRL_GO_DEACT];

    // Next control values
    always_comb begin
        enable_next = enable_reg;
        auto_deact_next = auto_deact_reg;
        pwr_inv_next = pwr_inv_reg;
        if (wr_ctrl) begin
            enable_next = wd[SCPC_CTRL_ENABLE];
            auto_deact_next = wd[SCPC_CTRL_AUTO_DEACT];
            pwr_inv_next = wd[SCPC_CTRL_PWR_INV];
        end
    end

    // Register control values
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            enable_reg <= SCPC_RST_ENABLE;
            auto_deact_reg <= SCPC_RST_AUTO_DEACT;
            pwr_inv_reg <= SCPC_RST_PWR_INV;
        end else begin
            enable_reg <= enable_next;
            auto_deact_reg <= auto_deact_next;
            pwr_inv_reg <= pwr_inv_next;
        end
    end

    // ********
    // Insertion and removal detection
    // ********
    logic prev_reg; // Level seen last cycle, sampled whether or not enabled
    logic prev_next;
    logic armed_reg; // Detection running
    logic armed_next;
    logic ev_ins; // Insertion pulse
    logic ev_rem; // Removal pulse

    // Edges count only once armed; the level is sampled every cycle, so turning
    // the interface on with a card already seated is not an insertion
    assign ev_ins = armed_reg && detect_level && !prev_reg; // [RULE_05]
    assign ev_rem = armed_reg && !detect_level && prev_reg; // [RULE_05]

    // Next detection state
    always_comb begin
        armed_next = enable_reg; // [RULE_05]
        prev_next = detect_level;
    end

    // Register detection state
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            armed_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            armed_reg <= armed_next;
            prev_reg <= prev_next;
        end
    end

    // ********
    // Sequencer
    // ********
    logic seq_busy; // Sequence running
    logic seq_rst; // Reset level from sequencer
    logic seq_pwr; // Power level from sequencer
    logic seq_done; // Sequence finished pulse
    logic go_deact; // Software or automatic deactivation

    // Removal with auto deactivation aborts a running activation or warm reset
    assign go_deact = go_deact_sw || (ev_rem && auto_deact_reg); // [RULE_12]

    scpc_seq u_seq (
        .core_clk(core_clk),
        .rstn(rstn),
        .go_act(go_act),
        .go_warm(go_warm),
        .go_deact(go_deact),
        .busy(seq_busy),
        .seq_rst(seq_rst),
        .seq_pwr(seq_pwr),
        .done(seq_done)
    ); // [RULE_12]

    // ********
    // Pin control and status register
    // ********
    logic rst_reg; // Drives card_reset_line
    logic rst_next;
    logic pwr_en_reg; // power_enable_signal as stored
    logic pwr_en_next;
    logic pwr_pin_reg; // Drives card_power_pin
    logic pwr_pin_next;
    logic ins_flag_reg; // card_inserted_flag
    logic ins_flag_next;
    logic rem_flag_reg; // card_removed_flag
    logic rem_flag_next;

    // Next pin and flag values
    always_comb begin
        rst_next = rst_reg;
        pwr_en_next = pwr_en_reg;
        if (seq_busy) begin
            // Hardware owns the pins; software writes are dropped
            rst_next = seq_rst; // [RULE_08]
            pwr_en_next = seq_pwr ^ pwr_inv_reg; // [RULE_08]
        end else if (wr_pin) begin
            rst_next = wd[SCPC_PIN_RST]; // [RULE_06]
            pwr_en_next = wd[SCPC_PIN_PWR];
        end
        pwr_pin_next = pwr_en_next ^ pwr_inv_next; // [RULE_09]
        // Write one clears, write zero is ignored; set beats clear
        ins_flag_next = ins_flag_reg;
        rem_flag_next = rem_flag_reg;
        if (wr_pin && wd[SCPC_PIN_INS]) begin
            ins_flag_next = 1'b0; // [RULE_04]
        end
        if (wr_pin && wd[SCPC_PIN_REM]) begin
            rem_flag_next = 1'b0; // [RULE_04]
        end
        if (ev_ins) begin
            ins_flag_next = 1'b1; // [RULE_02]
        end
        if (ev_rem) begin
            rem_flag_next = 1'b1; // [RULE_03]
        end
    end

    // Register pins and flags
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rst_reg <= SCPC_RST_RESET_LINE;
            pwr_en_reg <= SCPC_RST_PWR_EN;
            pwr_pin_reg <= SCPC_RST_PWR_EN ^ SCPC_RST_PWR_INV;
            ins_flag_reg <= 1'b0;
            rem_flag_reg <= 1'b0;
        end else begin
            rst_reg <= rst_next;
            pwr_en_reg <= pwr_en_next;
            pwr_pin_reg <= pwr_pin_next;
            ins_flag_reg <= ins_flag_next;
            rem_flag_reg <= rem_flag_next;
        end
    end

    assign card_reset_line = rst_reg; // [RULE_06]
    assign card_power_pin = pwr_pin_reg; // [RULE_09]

    // ********
    // Interrupt status and enable
    // ********
    logic [SCPC_EV_W-1:0] ev_vec; // Events this cycle
    logic [SCPC_EV_W-1:0] stat_reg; // Sticky status
    logic [SCPC_EV_W-1:0] stat_next;
    logic [SCPC_EV_W-1:0] int_en_reg; // Enable mask
    logic [SCPC_EV_W-1:0] int_en_next;
    logic irq_reg; // Registered interrupt level
    logic irq_next;

    always_comb begin
        ev_vec = '0;
        ev_vec[SCPC_EV_INS] = ev_ins;
        ev_vec[SCPC_EV_REM] = ev_rem;
        ev_vec[SCPC_EV_SEQ_END] = seq_done; // [RULE_12]
    end

    // Clear by write-one, but a same-cycle event keeps its bit
    always_comb begin
        stat_next = stat_reg;
        if (wr_clr) begin
            stat_next = stat_next & ~wd[SCPC_EV_W-1:0];
        end
        stat_next = stat_next | ev_vec;
        int_en_next = wr_en ? wd[SCPC_EV_W-1:0] : int_en_reg;
        irq_next = |(stat_next & int_en_next);
    end

    // Register status, mask and interrupt
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            stat_reg <= '0;
            int_en_reg <= SCPC_RST_INT_EN;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            int_en_reg <= int_en_next;
            irq_reg <= irq_next;
        end
    end

    assign irq = irq_reg;

    // ********
    // Read path, data one cycle after the strobe
    // ********
    logic [SCPC_DATA_W-1:0] rdata_reg; // Read data
    logic [SCPC_DATA_W-1:0] rdata_next;

    // Pin bits read back the pins, not what was written
    always_comb begin
        rdata_next = '0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                SCPC_OFF_CTRL: begin
                    rdata_next[SCPC_CTRL_ENABLE] = enable_reg;
                    rdata_next[SCPC_CTRL_AUTO_DEACT] = auto_deact_reg;
                    rdata_next[SCPC_CTRL_PWR_INV] = pwr_inv_reg;
                end
                SCPC_OFF_PIN: begin
                    rdata_next[SCPC_PIN_PWR] = pwr_pin_reg; // [RULE_10]
                    rdata_next[SCPC_PIN_RST] = rst_reg; // [RULE_07]
                    rdata_next[SCPC_PIN_REM] = rem_flag_reg;
                    rdata_next[SCPC_PIN_INS] = ins_flag_reg;
                    rdata_next[SCPC_PIN_DETECT] = detect_level; // [RULE_01]
                    rdata_next[SCPC_PIN_RSVD] = 1'b0; // [RULE_11]
                end
                SCPC_OFF_INT_STAT: rdata_next[SCPC_EV_W-1:0] = stat_reg;
                SCPC_OFF_INT_EN: rdata_next[SCPC_EV_W-1:0] = int_en_reg;
                default: rdata_next = '0; // Unmapped and write-only read zero
            endcase
        end
    end

    // Register read data; zero outside the answer cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;

endmodule

// ### scpc_socket.sv
// Card socket model: a card-detect switch that closes while a card sits in it
`timescale 1ns/1ps
module scpc_socket (
    input wire logic card_present,
    output logic card_detect_pin
);
    // ********
    // Switch
    // ********
    // Settles a few ns after the card moves, so never exactly on a clock edge
    initial card_detect_pin = 1'b0;
    always @(card_present) begin
        card_detect_pin <= #3 card_present;
    end
endmodule

// ### scpc_top_asserts.sv
// Port-level assertions for the pin control and status block
`timescale 1ns/1ps
module scpc_top_asserts
    import scpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire scpc_bus_req_t bus_req,
    input wire logic [SCPC_DATA_W-1:0] rdata,
    input wire logic card_detect_pin,
    input wire logic card_reset_line,
    input wire logic card_power_pin,
    input wire logic irq
);
    // ********
    // Helper state
    // ********
    logic [8:0] quiet_reg, quiet_next; // Since last control write or pin move, max 400
    logic [3:0] stab_reg, stab_next; // Detect pin steady cycles
    logic pin_reg, pin_next; // Detect pin one cycle ago
    logic inv_reg, inv_next; // Mirror of the power invert bit
    logic [SCPC_EV_W-1:0] ien_reg, ien_next; // Mirror of the event enables
    logic ctrl_wr, pin_wr, pin_rd, moved;
    assign ctrl_wr = bus_req.wr && bus_req.addr == SCPC_OFF_CTRL;
    assign pin_wr = bus_req.wr && bus_req.addr == SCPC_OFF_PIN;
    assign pin_rd = bus_req.rd && bus_req.addr == SCPC_OFF_PIN;
    assign moved = card_detect_pin != pin_reg;
    // Quiet past any sequence length: software owns the pins
    always_comb begin
        pin_next = card_detect_pin;
        stab_next = moved ? 4'h0 : stab_reg + {3'h0, stab_reg != 4'hf};
        quiet_next = (ctrl_wr || moved) ? 9'h0 : quiet_reg + {8'h0, quiet_reg != 9'h190};
        inv_next = ctrl_wr ? bus_req.wdata[SCPC_CTRL_PWR_INV] : inv_reg;
        ien_next = (bus_req.wr && bus_req.addr == SCPC_OFF_INT_EN) ?
            bus_req.wdata[SCPC_EV_W-1:0] : ien_reg;
    end
    // Registers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            {quiet_reg, stab_reg, pin_reg, inv_reg, ien_reg} <= '0;
        end else begin
            {quiet_reg, stab_reg, pin_reg} <= {quiet_next, stab_next, pin_next};
            {inv_reg, ien_reg} <= {inv_next, ien_next};
        end
    end
    // ********
    // Assertions
    // ********
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    AST_RDATA_IDLE: assert property (!bus_req.rd |=> rdata == '0)
        else $error("read data not zero outside a read");
    AST_RST_DRIVE: assert property (pin_wr && quiet_reg == 9'h190 |=>
        card_reset_line == $past(bus_req.wdata[SCPC_PIN_RST]))
        else $error("reset pin does not follow write");
    AST_PWR_XOR: assert property (pin_wr && quiet_reg == 9'h190 |=>
        card_power_pin == ($past(bus_req.wdata[SCPC_PIN_PWR]) ^ inv_reg))
        else $error("power pin is not enable xor invert");
    AST_RST_READ: assert property (pin_rd |=> rdata[SCPC_PIN_RST] == $past(card_reset_line))
        else $error("reset bit read differs from pin");
    AST_PWR_READ: assert property (pin_rd |=> rdata[SCPC_PIN_PWR] == $past(card_power_pin))
        else $error("power bit read differs from pin");
    AST_RSVD: assert property (pin_rd |=> !rdata[SCPC_PIN_RSVD])
        else $error("reserved bit reads one");
    AST_DETECT: assert property (pin_rd && stab_reg >= 4'h6 |=>
        rdata[SCPC_PIN_DETECT] == $past(card_detect_pin))
        else $error("detect bit differs from steady pin");
    AST_FLAG_CLR: assert property (pin_wr ##2 pin_rd && stab_reg >= 4'h8 |=>
        (rdata[3:2] & $past(bus_req.wdata[3:2], 3)) == 2'h0)
        else $error("flag survives write of one");
    AST_IRQ_MASK: assert property (ien_reg == '0 |-> !irq)
        else $error("interrupt with all events disabled");
endmodule

bind scpc_top scpc_top_asserts u_chk (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
    .rdata(rdata), .card_detect_pin(card_detect_pin), .card_reset_line(card_reset_line),
    .card_power_pin(card_power_pin), .irq(irq));

// ### scpc_top_bench.sv
// Self-checking bench for the pin control and status block
`timescale 1ns/1ps
module scpc_top_bench import scpc_pkg::*;;
    // ********
    // Signals
    // ********
    logic core_clk = 1'b0; // 100 MHz
    logic rstn = 1'b0; // Held low for 8 cycles
    scpc_bus_req_t bus_req = '0; // Register requests
    logic [SCPC_DATA_W-1:0] rdata, word, d;
    logic card_present = 1'b0; // Card sits in the socket
    logic card_detect_pin, card_reset_line, card_power_pin, irq;
    int fails = 0;
    int tests_run = 0;
    int seed = 32'h79683928;
    logic [7:0] go_tab [4] = '{8'h11, 8'h21, 8'h41, 8'h13}; // Act, warm, deact, act+auto
    logic [1:0] end_tab [4] = '{2'h3, 2'h3, 2'h0, 2'h3}; // Final {reset, power}
    always #5 core_clk = ~core_clk;
    scpc_top u_dut (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
        .card_detect_pin(card_detect_pin), .card_reset_line(card_reset_line),
        .card_power_pin(card_power_pin), .irq(irq));
    scpc_socket u_socket (.card_present(card_present), .card_detect_pin(card_detect_pin));
    // ********
    // Tasks
    // ********
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Called after an edge; ends with a gap cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string n);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 word = rdata; // Read data stand only in this cycle
        @(posedge core_clk);
        check(n, word & m, e);
    endtask
    function automatic logic [31:0] pin_word(logic det, logic ins, logic rem, logic rst,
        logic pwr);
        return {26'h0, 1'b0, det, ins, rem, rst, pwr};
    endfunction
    task automatic card(input logic v);
        card_present <= v;
        repeat (12) @(posedge core_clk); // Synchroniser and flag latency
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 500 && irq !== 1'b1; n++) @(posedge core_clk);
        check("irq", {31'h0, irq}, 32'h1);
    endtask
    task automatic end_of_test();
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        chk_rd(SCPC_OFF_PIN, 32'h3f, 32'h0, "pin idle");
        card(1'b1); // Detection still disabled: level only
        chk_rd(SCPC_OFF_PIN, 32'h3c, 32'h10, "off");
        card(1'b0);
        wr(SCPC_OFF_INT_EN, 32'h3);
        wr(SCPC_OFF_CTRL, 32'h1);
        card(1'b1);
        chk_rd(SCPC_OFF_PIN, 32'h3c, 32'h18, "ins");
        check("irq ins", {31'h0, irq}, 32'h1);
        wr(SCPC_OFF_PIN, 32'h0); // Zero leaves the flag alone
        chk_rd(SCPC_OFF_PIN, 32'hc, 32'h8, "zero write");
        wr(SCPC_OFF_PIN, 32'hc); // Ones clear, never set
        chk_rd(SCPC_OFF_PIN, 32'hc, 32'h0, "one write");
        card(1'b0);
        chk_rd(SCPC_OFF_PIN, 32'h3c, 32'h4, "rem");
        chk_rd(SCPC_OFF_INT_STAT, 32'h3, 32'h3, "status");
        wr(SCPC_OFF_PIN, 32'h4);
        chk_rd(SCPC_OFF_PIN, 32'hc, 32'h0, "rem clear");
        wr(SCPC_OFF_INT_CLR, 32'h7);
        wr(SCPC_OFF_INT_EN, 32'h0);
        // Software pin control, both inverts, random bits
        for (int inv = 0; inv < 2; inv++) begin
            wr(SCPC_OFF_CTRL, {29'h0, inv[0], 2'h1});
            repeat (410) @(posedge core_clk);
            for (int k = 0; k < 8; k++) begin
                d = $random(seed);
                d[0] = k[0];
                wr(SCPC_OFF_PIN, d);
                check("rst pin", {31'h0, card_reset_line}, {31'h0, d[1]});
                check("pwr pin", {31'h0, card_power_pin}, {31'h0, d[0] ^ inv[0]});
                chk_rd(SCPC_OFF_PIN, 32'h3f, pin_word(1'b0, 1'b0, 1'b0, d[1], d[0] ^ inv[0]),
                    "pin rw");
            end
        end
        // Sequences own the pins; software writes dropped
        wr(SCPC_OFF_INT_EN, 32'h4);
        card(1'b1);
        for (int s = 0; s < 4; s++) begin
            wr(SCPC_OFF_INT_CLR, 32'h4);
            wr(SCPC_OFF_CTRL, {24'h0, go_tab[s]});
            repeat (20) @(posedge core_clk);
            wr(SCPC_OFF_PIN, 32'h2);
            check("busy write", {31'h0, card_reset_line}, 32'h0);
            wait_irq();
            check("seq pins", {30'h0, card_reset_line, card_power_pin}, {30'h0, end_tab[s]});
        end
        chk_rd(SCPC_OFF_CTRL, 32'h7f, 32'h3, "ctrl");
        chk_rd(SCPC_OFF_INT_EN, 32'h7, 32'h4, "int en");
        wr(SCPC_OFF_INT_CLR, 32'h4);
        wr(SCPC_OFF_CTRL, 32'h13); // Removal mid activation must abort it
        repeat (20) @(posedge core_clk);
        card_present <= 1'b0;
        wait_irq();
        check("auto", {30'h0, card_reset_line, card_power_pin}, 32'h0);
        end_of_test();
    end
    // Watchdog, far beyond the run's length
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        end_of_test();
    end
endmodule
